// [common/expander_if.sv]
`timescale 1ns/1ps
interface expander_if;
  logic scl_o, scl_oe;
  logic sda_o, sda_oe;
  logic dev_sda_o, dev_sda_oe;
  wire scl = !(scl_oe && !scl_o);
  wire sda = !((sda_oe && !sda_o) || (dev_sda_oe && !dev_sda_o));
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport controller (input scl, input sda, output scl_o, output scl_oe,
    output sda_o, output sda_oe);
endinterface

// [common/expander_pkg.sv]
// What this block does
// - Two select pins each decode four states
// - Bus-line pin 1 gives 10h-13h, 18h-1Bh
// - Static pin 1 gives 20h-23h, 28h-2Bh
// - First byte low bit: one reads, zero writes
// - General call acknowledged for write only
// - Reset byte acknowledged only when 06h
// - No acknowledge after first general-call byte
// - Stop after reset byte restores defaults
// - Repeated start after reset byte: no reset
// - Controller reports missing acknowledge on acked, no abort
// - Hardwired 24-bit maker, part, revision word
// - ID setup: F8h then matching target address
// - Repeated start then F9h returns ID bytes
// - Stop then start abandons ID read
// - Other target access abandons pending ID read
// - ID sent MSB first, maker code leading
// - Controller nack ends ID read, bus released
// - ID bytes wrap after third while acknowledged
// - Each acknowledged data byte to own address drives port pins
// - Read returns current port pin levels
// - Reset sets port value to all ones
package expander_pkg;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [7:0] SW_RESET_BYTE = 8'h06;
  localparam logic [6:0] ID_ADDR = 7'h7C;
  localparam logic [6:0] BASE_HI_BUS = 7'h10;
  localparam logic [6:0] BASE_BOTH_BUS = 7'h18;
  localparam logic [6:0] BASE_STATIC = 7'h20;
  localparam logic [6:0] BASE_LO_BUS = 7'h28;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [11:0] MAKER_CODE = 12'hA5A; // Arbitrary value
  localparam logic [8:0] PART_CODE = 9'h0C3; // Arbitrary value
  localparam logic [2:0] DIE_REV = 3'h1; // Arbitrary value
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SCL_KHZ = 8000;
  localparam logic [7:0] SCL_HALF_CYC = 8'(CLK_MHZ * 1000 / SCL_KHZ / 2);
  // Select pin states
  typedef enum logic [1:0] {SEL_GND, SEL_VDD, SEL_SCL, SEL_SDA} sel_t;
endpackage

// [hdl/expander_controller.sv]
`timescale 1ns/1ps
module expander_controller (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, low
  expander_if.controller bus, // Two-wire bus
  input wire logic req, // Start one byte step, pulse
  input wire logic [1:0] req_kind, // 0 byte,1 start+byte,2 stop,3 read
  input wire logic req_last, // Read: send nack
  input wire logic [7:0] req_data, // Byte to send
  output logic done, // Step finished, pulse
  output logic acked, // Target acknowledged
  output logic [7:0] rdata // Byte read
);
  typedef enum {C_IDLE, C_START, C_BIT, C_ACK, C_STOP} cst_t;
  logic [2:0] sda_s;
  cst_t st_reg, st_next;
  logic [7:0] div_reg, div_next, sh_reg, sh_next, rd_reg, rd_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] ph_reg, ph_next;
  logic scl_reg, scl_next, sda_reg, sda_next, rd_mode_reg, rd_mode_next;
  logic last_reg, last_next, done_reg, done_next, ack_reg, ack_next;
  logic tick;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sda_s <= 3'h7;
    else sda_s <= {sda_s[1:0], bus.sda};
  end
  assign tick = div_reg == 8'h00;
  always_comb begin
    st_next = st_reg;
    div_next = tick ? expander_pkg::SCL_HALF_CYC - 8'h01 : div_reg - 8'h01;
    sh_next = sh_reg;
    rd_next = rd_reg;
    bit_next = bit_reg;
    ph_next = ph_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    rd_mode_next = rd_mode_reg;
    last_next = last_reg;
    done_next = 1'b0;
    ack_next = ack_reg;
    case (st_reg)
      C_IDLE: if (req) begin
        sh_next = req_data;
        rd_mode_next = req_kind == 2'h3;
        last_next = req_last;
        bit_next = 4'h0;
        ph_next = 2'h0;
        div_next = expander_pkg::SCL_HALF_CYC - 8'h01;
        case (req_kind)
          2'h1: st_next = C_START;
          2'h2: st_next = C_STOP;
          default: st_next = C_BIT;
        endcase
      end
      C_START: if (tick) begin
        ph_next = ph_reg + 2'h1;
        case (ph_reg)
          2'h0: sda_next = 1'b1;
          2'h1: scl_next = 1'b1;
          2'h2: sda_next = 1'b0;
          default: begin
            scl_next = 1'b0;
            st_next = C_BIT;
          end
        endcase
      end
      C_BIT: if (tick) begin
        if (!scl_reg) begin
          sda_next = rd_mode_reg ? 1'b1 : sh_reg[7];
          scl_next = ph_reg == 2'h1;
          ph_next = ph_reg == 2'h1 ? 2'h0 : 2'h1;
        end else begin
          scl_next = 1'b0;
          rd_next = {rd_reg[6:0], sda_s[1]};
          sh_next = {sh_reg[6:0], 1'b1};
          bit_next = bit_reg + 4'h1;
          if (bit_reg == 4'h7) st_next = C_ACK;
        end
      end
      C_ACK: if (tick) begin
        if (!scl_reg) begin
          sda_next = rd_mode_reg ? last_reg : 1'b1;
          scl_next = ph_reg == 2'h1;
          ph_next = ph_reg == 2'h1 ? 2'h0 : 2'h1;
        end else begin
          scl_next = 1'b0;
          ack_next = !sda_s[1];
          done_next = 1'b1;
          st_next = C_IDLE;
        end
      end
      C_STOP: if (tick) begin
        ph_next = ph_reg + 2'h1;
        case (ph_reg)
          2'h0: sda_next = 1'b0;
          2'h1: scl_next = 1'b1;
          2'h2: sda_next = 1'b1;
          default: begin
            done_next = 1'b1;
            st_next = C_IDLE;
          end
        endcase
      end
      default: st_next = C_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= C_IDLE;
      div_reg <= 8'h00;
      sh_reg <= 8'h00;
      rd_reg <= 8'h00;
      bit_reg <= 4'h0;
      ph_reg <= 2'h0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rd_mode_reg <= 1'b0;
      last_reg <= 1'b0;
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      bit_reg <= bit_next;
      ph_reg <= ph_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      rd_mode_reg <= rd_mode_next;
      last_reg <= last_next;
      done_reg <= done_next;
      ack_reg <= ack_next;
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = !scl_reg;
  assign bus.sda_o = 1'b0;
  assign bus.sda_oe = !sda_reg;
  assign done = done_reg;
  assign acked = ack_reg;
  assign rdata = rd_reg;
endmodule // expander_controller

// [hdl/expander_target.sv]
`timescale 1ns/1ps
module expander_target (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, low
  expander_if.device bus, // Two-wire bus
  input wire logic [1:0] addr_select_hi_pin, // Strap state, sel_t
  input wire logic [1:0] addr_select_lo_pin, // Strap state, sel_t
  input wire logic [7:0] port_in, // Pin levels seen
  output logic [7:0] port_pins, // Port latch value
  output logic busy // Transfer in progress
);
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_WDATA, S_WACK, S_RDATA, S_RACK,
    S_IGNORE} st_t;
  logic [2:0] scl_s, sda_s;
  logic [7:0] port_s1, port_s2;
  logic [1:0] hi_s1, hi_s2, lo_s1, lo_s2;
  logic sda_f, scl_rise, scl_fall, start_c, stop_c;
  st_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next, port_reg, port_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [1:0] idb_reg, idb_next;
  logic gc_reg, gc_next, rst_ok_reg, rst_ok_next;
  logic id_arm_reg, id_arm_next, id_rd_reg, id_rd_next;
  logic first_reg, first_next, ack_reg, ack_next;
  logic sda_oe_reg, sda_oe_next, busy_reg, busy_next;
  logic [6:0] my_addr;
  logic [23:0] id_word;
  logic [7:0] id_byte;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      port_s1 <= expander_pkg::PORT_RESET;
      port_s2 <= expander_pkg::PORT_RESET;
      hi_s1 <= 2'h0;
      hi_s2 <= 2'h0;
      lo_s1 <= 2'h0;
      lo_s2 <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
      port_s1 <= port_in;
      port_s2 <= port_s1;
      hi_s1 <= addr_select_hi_pin;
      hi_s2 <= hi_s1;
      lo_s1 <= addr_select_lo_pin;
      lo_s2 <= lo_s1;
    end
  end
  assign sda_f = sda_s[1];
  assign scl_rise = scl_s[1] && !scl_s[2];
  assign scl_fall = !scl_s[1] && scl_s[2];
  assign start_c = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign stop_c = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
  // Address decode from the two four-state selects
  always_comb begin
    logic hb, lb;
    hb = hi_s2[0];
    lb = lo_s2[0];
    if (hi_s2[1] && !lo_s2[1])
      my_addr = expander_pkg::BASE_HI_BUS | {5'h00, hb, lb};
    else if (hi_s2[1])
      my_addr = expander_pkg::BASE_BOTH_BUS | {5'h00, hb, lb};
    else if (!lo_s2[1])
      my_addr = expander_pkg::BASE_STATIC | {5'h00, hb, lb};
    else
      my_addr = expander_pkg::BASE_LO_BUS | {5'h00, hb, lb};
  end
  assign id_word = {expander_pkg::MAKER_CODE, expander_pkg::PART_CODE,
    expander_pkg::DIE_REV};
  always_comb begin
    case (idb_reg)
      2'h0: id_byte = id_word[23:16];
      2'h1: id_byte = id_word[15:8];
      default: id_byte = id_word[7:0];
    endcase
  end
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    port_next = port_reg;
    cnt_next = cnt_reg;
    idb_next = idb_reg;
    gc_next = gc_reg;
    rst_ok_next = rst_ok_reg;
    id_arm_next = id_arm_reg;
    id_rd_next = id_rd_reg;
    first_next = first_reg;
    ack_next = ack_reg;
    sda_oe_next = sda_oe_reg;
    busy_next = busy_reg;
    if (stop_c) begin
      st_next = S_IDLE;
      sda_oe_next = 1'b0;
      busy_next = 1'b0;
      id_arm_next = 1'b0;
      rst_ok_next = 1'b0;
      gc_next = 1'b0;
      if (rst_ok_reg) begin
        port_next = expander_pkg::PORT_RESET;
        idb_next = 2'h0;
      end
    end else if (start_c) begin
      st_next = S_ADDR;
      cnt_next = 3'h0;
      sda_oe_next = 1'b0;
      busy_next = 1'b1;
      rst_ok_next = 1'b0;
      gc_next = 1'b0;
      id_rd_next = 1'b0;
    end else begin
      case (st_reg)
        S_ADDR, S_WDATA: if (scl_rise) begin
          sh_next = {sh_reg[6:0], sda_f};
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) st_next = (st_reg == S_ADDR) ? S_AACK : S_WACK;
        end
        S_AACK: if (scl_fall && !sda_oe_reg) begin
          ack_next = 1'b0;
          id_rd_next = 1'b0;
          id_arm_next = 1'b0;
          if (sh_reg == {expander_pkg::GEN_CALL_ADDR, 1'b0}) begin
            ack_next = 1'b1;
            gc_next = 1'b1;
            first_next = 1'b1;
          end else if (sh_reg == {expander_pkg::ID_ADDR, 1'b0}) begin
            ack_next = 1'b1;
            first_next = 1'b1;
          end else if (sh_reg == {expander_pkg::ID_ADDR, 1'b1}) begin
            ack_next = id_arm_reg;
            id_rd_next = id_arm_reg;
            idb_next = 2'h0;
          end else if (sh_reg[7:1] == my_addr) begin
            ack_next = 1'b1;
            first_next = 1'b0;
          end
          sda_oe_next = ack_next;
          if (!ack_next) st_next = S_IGNORE;
        end else if (scl_fall) begin
          sda_oe_next = 1'b0;
          cnt_next = 3'h0;
          if (sh_reg[0]) begin
            st_next = S_RDATA;
            sh_next = id_rd_reg ? id_byte : port_s2;
            sda_oe_next = id_rd_reg ? !id_byte[7] : !port_s2[7];
          end else
            st_next = S_WDATA;
        end
        S_WACK: if (scl_fall && !sda_oe_reg) begin
          ack_next = 1'b0;
          if (gc_reg) begin
            ack_next = first_reg && sh_reg == expander_pkg::SW_RESET_BYTE;
            rst_ok_next = ack_next;
          end else if (first_reg) begin
            ack_next = sh_reg[7:1] == my_addr;
            id_arm_next = ack_next;
          end else begin
            ack_next = 1'b1;
            port_next = sh_reg;
          end
          first_next = 1'b0;
          sda_oe_next = ack_next;
          if (!ack_next) st_next = S_IGNORE;
        end else if (scl_fall) begin
          sda_oe_next = 1'b0;
          cnt_next = 3'h0;
          st_next = S_WDATA;
        end
        S_RDATA: if (scl_fall) begin
          cnt_next = cnt_reg + 3'h1;
          sh_next = {sh_reg[6:0], 1'b1};
          sda_oe_next = (cnt_reg == 3'h7) ? 1'b0 : !sh_reg[6];
          if (cnt_reg == 3'h7) st_next = S_RACK;
        end
        S_RACK: if (scl_rise) begin
          if (sda_f) begin
            st_next = S_IGNORE;
            id_rd_next = 1'b0;
            id_arm_next = 1'b0;
          end else if (id_rd_reg)
            idb_next = (idb_reg == 2'h2) ? 2'h0 : idb_reg + 2'h1;
        end else if (scl_fall) begin
          st_next = S_RDATA;
          cnt_next = 3'h0;
          sh_next = id_rd_reg ? id_byte : port_s2;
          sda_oe_next = id_rd_reg ? !id_byte[7] : !port_s2[7];
        end
        S_IGNORE: sda_oe_next = 1'b0;
        default: st_next = S_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= S_IDLE;
      sh_reg <= 8'h00;
      port_reg <= expander_pkg::PORT_RESET;
      cnt_reg <= 3'h0;
      idb_reg <= 2'h0;
      gc_reg <= 1'b0;
      rst_ok_reg <= 1'b0;
      id_arm_reg <= 1'b0;
      id_rd_reg <= 1'b0;
      first_reg <= 1'b0;
      ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      port_reg <= port_next;
      cnt_reg <= cnt_next;
      idb_reg <= idb_next;
      gc_reg <= gc_next;
      rst_ok_reg <= rst_ok_next;
      id_arm_reg <= id_arm_next;
      id_rd_reg <= id_rd_next;
      first_reg <= first_next;
      ack_reg <= ack_next;
      sda_oe_reg <= sda_oe_next;
      busy_reg <= busy_next;
    end
  end
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_reg;
  assign port_pins = port_reg;
  assign busy = busy_reg;
endmodule // expander_target

// [tb/expander_bus_chk.sv]
`timescale 1ns/1ps
module expander_bus_chk (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic scl, // Bus clock line
  input wire logic sda, // Bus data line
  input wire logic scl_oe, // Controller clock drive
  input wire logic sda_oe, // Controller data drive
  input wire logic dev_sda_oe // Target data drive
);
  logic sclq, sdaq, nak;
  logic [3:0] bn;
  logic [7:0] sh, fb, nb;
  wire st = sclq && scl && sdaq && !sda;
  wire rise = scl && !sclq;
  // Ninth clock of a byte
  wire ar = rise && bn == 4'h8;
  wire rdx = fb[0] && nb != 8'h00;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclq <= 1'b1;
      sdaq <= 1'b1;
      nak <= 1'b0;
      bn <= 4'h0;
      sh <= 8'h00;
      fb <= 8'hFF;
      nb <= 8'h00;
    end else begin
      sclq <= scl;
      sdaq <= sda;
      if (st) begin
        bn <= 4'h0;
        nb <= 8'h00;
        nak <= 1'b0;
      end else if (ar) begin
        bn <= 4'h0;
        nb <= nb + 8'h01;
        if (nb == 8'h00) fb <= sh;
        if (rdx && sda) nak <= 1'b1;
      end else if (rise) begin
        bn <= bn + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  reset_rel_a: assert property ($rose(arst_n) |->
    !dev_sda_oe && !sda_oe && !scl_oe) else $error("bus held after reset");
  oe_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data changed with clock high");
  gc_rd_nack_a: assert property (
    ar && nb == 8'h00 && sh == 8'h01 |-> !dev_sda_oe)
    else $error("general call read acknowledged");
  gc_wr_ack_a: assert property (
    ar && nb == 8'h00 && sh == 8'h00 |-> dev_sda_oe)
    else $error("general call write not acknowledged");
  rst_byte_a: assert property (
    ar && nb == 8'h01 && fb == 8'h00 |-> dev_sda_oe == (sh == 8'h06))
    else $error("reset byte acknowledge wrong");
  gc_extra_a: assert property (
    ar && nb > 8'h01 && fb == 8'h00 |-> !dev_sda_oe)
    else $error("extra general call byte acknowledged");
  id_setup_a: assert property (
    ar && nb == 8'h00 && sh == 8'hF8 |-> dev_sda_oe)
    else $error("identification setup not acknowledged");
  rd_slot_a: assert property (ar && rdx |-> !dev_sda_oe)
    else $error("target drove controller acknowledge slot");
  nak_rel_a: assert property (nak |-> !dev_sda_oe)
    else $error("target drove after controller nack");
  cover property (ar && nb == 8'h01 && fb == 8'h00 && dev_sda_oe);
  cover property ($rose(nak));
  cover property (ar && rdx && !sda);
endmodule // expander_bus_chk

// [tb/test_expander_bus_address_reset_id.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_expander_bus_address_reset_id;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req = 1'b0;
  logic req_last = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [1:0] sel_hi = 2'h0;
  logic [1:0] sel_lo = 2'h0;
  logic [7:0] req_data = 8'h00;
  logic [7:0] port_in = 8'h00;
  logic [7:0] port_pins, rdata, d1, d2, pv;
  logic done, acked, busy;
  logic [6:0] ad;
  logic [10:0] nt;
  logic [23:0] idw;
  logic [10:0] notes[$];
  int error_cnt = 0;
  int compares = 0;
  int seed = 92936;
  int i;
  expander_if bus_if();
  always #2 clk = ~clk;
  expander_target i_expander_target(.clk(clk), .arst_n(arst_n),
    .bus(bus_if), .addr_select_hi_pin(sel_hi), .addr_select_lo_pin(sel_lo),
    .port_in(port_in), .port_pins(port_pins), .busy(busy));
  expander_controller i_expander_controller(.clk(clk), .arst_n(arst_n),
    .bus(bus_if), .req(req), .req_kind(req_kind), .req_last(req_last),
    .req_data(req_data), .done(done), .acked(acked), .rdata(rdata));
  expander_bus_chk i_expander_bus_chk(.clk(clk), .arst_n(arst_n),
    .scl(bus_if.scl), .sda(bus_if.sda), .scl_oe(bus_if.scl_oe),
    .sda_oe(bus_if.sda_oe), .dev_sda_oe(bus_if.dev_sda_oe));
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Note: check ack, check data, ack, data
  task automatic step(input logic [1:0] k, input logic [7:0] d,
    input logic last, input logic [10:0] note);
    int n;
    notes.push_back(note);
    @(posedge clk);
    req <= 1'b1;
    req_kind <= k;
    req_data <= d;
    req_last <= last;
    @(posedge clk);
    req <= 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge clk);
    if (done !== 1'b1) begin
      error_cnt++;
      $display("BAD done exp 1 got %b", done);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [1:0] k, input logic [7:0] d, input logic a);
    step(k, d, 1'b0, {2'b10, a, 8'h00});
  endtask
  task automatic rd(input logic last, input logic [7:0] d);
    step(2'h3, 8'hFF, last, {3'b010, d});
  endtask
  task automatic stop_bus;
    step(2'h2, 8'h00, 1'b0, 11'h000);
  endtask
  function automatic logic [6:0] exp_addr(logic [1:0] h, logic [1:0] l);
    logic [6:0] b;
    case ({h, l})
      4'h0: b = 7'h20;
      4'h1: b = 7'h21;
      4'h2: b = 7'h28;
      4'h3: b = 7'h29;
      4'h4: b = 7'h22;
      4'h5: b = 7'h23;
      4'h6: b = 7'h2A;
      4'h7: b = 7'h2B;
      4'h8: b = 7'h10;
      4'h9: b = 7'h11;
      4'hA: b = 7'h18;
      4'hB: b = 7'h19;
      4'hC: b = 7'h12;
      4'hD: b = 7'h13;
      4'hE: b = 7'h1A;
      default: b = 7'h1B;
    endcase
    return b;
  endfunction
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        error_cnt++;
        $display("BAD notes exp 1 got 0");
      end else begin
        nt = notes.pop_front();
        if (nt[10]) `CHK("acked", nt[8], acked)
        if (nt[9]) `CHK("rdata", nt[7:0], rdata)
      end
    end
  end
  initial begin
    idw = {expander_pkg::MAKER_CODE, expander_pkg::PART_CODE,
      expander_pkg::DIE_REV};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("port_rst", expander_pkg::PORT_RESET, port_pins)
    `CHK("busy_rst", 1'b0, busy)
    for (i = 0; i < 16; i++) begin
      sel_hi <= i[3:2];
      sel_lo <= i[1:0];
      @(posedge clk);
      ad = exp_addr(i[3:2], i[1:0]);
      wr(2'h1, {ad ^ 7'h04, 1'b0}, 1'b0);
      wr(2'h1, {ad, 1'b0}, 1'b1);
      stop_bus();
    end
    sel_hi <= 2'h1;
    sel_lo <= 2'h3;
    ad = exp_addr(2'h1, 2'h3);
    d1 = 8'($random(seed));
    d2 = 8'($random(seed)) & 8'h7E;
    pv = 8'($random(seed));
    port_in <= pv;
    wr(2'h1, {ad, 1'b0}, 1'b1);
    wr(2'h0, d1, 1'b1);
    `CHK("busy_on", 1'b1, busy)
    wr(2'h0, d2, 1'b1);
    wr(2'h1, {ad, 1'b1}, 1'b1);
    rd(1'b0, pv);
    rd(1'b1, pv);
    stop_bus();
    `CHK("port_wr", d2, port_pins)
    wr(2'h1, 8'h01, 1'b0);
    wr(2'h1, 8'h00, 1'b1);
    wr(2'h0, 8'h07, 1'b0);
    stop_bus();
    wr(2'h1, 8'h00, 1'b1);
    wr(2'h0, 8'h06, 1'b1);
    wr(2'h0, 8'h06, 1'b0);
    stop_bus();
    wr(2'h1, 8'h00, 1'b1);
    wr(2'h0, 8'h06, 1'b1);
    wr(2'h1, {ad, 1'b0}, 1'b1);
    stop_bus();
    `CHK("port_sr", d2, port_pins)
    wr(2'h1, 8'h00, 1'b1);
    wr(2'h0, 8'h06, 1'b1);
    stop_bus();
    repeat (4) @(posedge clk);
    `CHK("port_swrst", expander_pkg::PORT_RESET, port_pins)
    `CHK("busy_sw", 1'b0, busy)
    wr(2'h1, 8'hF8, 1'b1);
    wr(2'h0, {ad, 1'b1}, 1'b1);
    wr(2'h1, 8'hF9, 1'b1);
    for (i = 0; i < 4; i++) rd(i == 3, idw[23 - 8 * (i % 3) -: 8]);
    stop_bus();
    wr(2'h1, 8'hF8, 1'b1);
    wr(2'h0, {ad, 1'b0}, 1'b1);
    stop_bus();
    wr(2'h1, 8'hF9, 1'b0);
    stop_bus();
    wr(2'h1, 8'hF8, 1'b1);
    wr(2'h0, {ad, 1'b0}, 1'b1);
    wr(2'h1, {ad ^ 7'h04, 1'b0}, 1'b0);
    wr(2'h1, 8'hF9, 1'b0);
    stop_bus();
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule // test_expander_bus_address_reset_id
